// *** core/ufw_pkg.sv ***
// Purpose: Shared constants for the USB buffer window and register block
// Assumes: 8-bit register port, 50 MHz clock
// Notes: Offsets are register-space addresses
// Behaviour
// - Five endpoints, IN and OUT, 64-byte buffers
// - Window reaches buffers only when enabled
// - Window base from high and low registers
// - Select register picks endpoint and direction
// - Select also picks control and size registers
// - Setup packet bytes go to command buffer
// - Setup index picks byte for value read
// - Unassigned engine answers address zero
// - Assigned address alone answers afterwards
// - Hardware reset clears device address
// - Pairing register bits pair buffer sets
// - Paired size write swaps active buffer
// - Enabled events share one interrupt output
// - Four enable registers, reset zero
// - Global flags: summaries high, events low
// - Per-endpoint done and refused flags
// - Control holds enable, window, wake bits
// - Buffer control bits, reset value 08
// - Size register holds seven-bit byte count
// - IN size write sets busy until sent
// - Busy buffer ignores processor access
// - OUT busy from start, count at end
// - Busy falling sets buffer event flag
package ufw_pkg;
  // ----------------------------------------
  // Sizes
  // ----------------------------------------
  localparam int NUM_EP = 5;
  localparam int NUM_BUF = 10;
  localparam int BUF_BYTES = 64;
  localparam int SETUP_BYTES = 8;
  // ----------------------------------------
  // Register offsets
  // ----------------------------------------
  localparam logic [7:0] OFS_DEVICE_ADDRESS = 8'he2;
  localparam logic [7:0] OFS_PAIRING = 8'he3;
  localparam logic [7:0] OFS_GLOBAL_ENABLE = 8'he4;
  localparam logic [7:0] OFS_IN_DONE_ENABLE = 8'he5;
  localparam logic [7:0] OFS_OUT_DONE_ENABLE = 8'he6;
  localparam logic [7:0] OFS_IN_REFUSED_ENABLE = 8'he7;
  localparam logic [7:0] OFS_GLOBAL_FLAGS = 8'he8;
  localparam logic [7:0] OFS_IN_DONE_FLAGS = 8'he9;
  localparam logic [7:0] OFS_OUT_DONE_FLAGS = 8'hea;
  localparam logic [7:0] OFS_IN_REFUSED_FLAGS = 8'heb;
  localparam logic [7:0] OFS_ENGINE_CONTROL = 8'hec;
  localparam logic [7:0] OFS_ENGINE_STATUS = 8'hed;
  localparam logic [7:0] OFS_SELECT = 8'hef;
  localparam logic [7:0] OFS_BUFFER_CONTROL = 8'hf1;
  localparam logic [7:0] OFS_BUFFER_SIZE = 8'hf2;
  localparam logic [7:0] OFS_BASE_HIGH = 8'hf3;
  localparam logic [7:0] OFS_BASE_LOW = 8'hf4;
  localparam logic [7:0] OFS_SETUP_INDEX = 8'hf5;
  localparam logic [7:0] OFS_SETUP_VALUE = 8'hf6;
  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int CTL_ENGINE_ENABLE = 2;
  localparam int CTL_WINDOW_ENABLE = 1;
  localparam int CTL_REMOTE_WAKE = 0;
  localparam int SEL_DIR = 7;
  localparam int CON_TOGGLE = 7;
  localparam int CON_STALL = 6;
  localparam int CON_ENABLE = 3;
  localparam int CON_BUSY = 0;
  localparam int PAIR_IN_ONE_TWO = 0;
  localparam int PAIR_IN_THREE_FOUR = 1;
  localparam int PAIR_OUT_ONE_TWO = 2;
  localparam int PAIR_OUT_THREE_FOUR = 3;
  localparam int STA_SETUP_SEEN = 0;
  // ----------------------------------------
  // Reset values
  // ----------------------------------------
  localparam logic [7:0] RST_BUFFER_CONTROL = 8'h08;
  localparam logic [6:0] RST_DEVICE_ADDRESS = 7'h00;
endpackage

// *** core/ufw_two_entry_buffer.sv ***
// Purpose: Two-entry valid/ready buffer
// Assumes: Source and sink on the same clock
// Notes: Full buffer holds the source off
`timescale 1ns/1ps
`default_nettype none
module ufw_two_entry_buffer #(
  parameter int WIDTH = 8
) (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic clk_en,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  typedef struct packed {
    logic [1:0][WIDTH-1:0] word;
    logic [1:0] count;
  } ufw_tb_s;
  ufw_tb_s st, next_st;
  logic push, pop;
  assign in_ready = (st.count != 2'h2);
  assign out_valid = (st.count != 2'h0);
  assign out_data = st.word[0];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  always_comb begin
    next_st = st;
    if (pop) begin
      next_st.word[0] = st.word[1];
    end
    if (push) begin
      if (st.count == 2'h0 || (st.count == 2'h1 && pop)) begin
        next_st.word[0] = in_data;
      end else begin
        next_st.word[1] = in_data;
      end
    end
    next_st.count = st.count + {1'b0, push} - {1'b0, pop};
  end
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      st <= '0;
    end else if (clk_en) begin
      st <= next_st;
    end
  end
endmodule
`default_nettype wire

// *** core/ufw_setup_store.sv ***
// Purpose: Eight-byte setup command store
// Assumes: Bytes arrive in packet order after a start pulse
// Notes: Stalls while the processor reads, single read port
`timescale 1ns/1ps
`default_nettype none
module ufw_setup_store (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic clk_en,
  input wire logic start,
  input wire logic byte_valid,
  output logic byte_ready,
  input wire logic [7:0] byte_data,
  input wire logic cpu_busy,
  input wire logic [2:0] rd_index,
  output logic [7:0] rd_byte,
  output logic done
);
  typedef struct packed {
    logic [ufw_pkg::SETUP_BYTES-1:0][7:0] cmd;
    logic [3:0] ptr;
    logic done;
  } ufw_ss_s;
  ufw_ss_s st, next_st;
  assign byte_ready = !cpu_busy;
  assign rd_byte = st.cmd[rd_index];
  assign done = st.done;
  always_comb begin
    next_st = st;
    next_st.done = 1'b0;
    if (start) begin
      next_st.ptr = 4'h0;
    end else if (byte_valid && byte_ready && st.ptr < 4'(ufw_pkg::SETUP_BYTES)) begin
      next_st.cmd[st.ptr[2:0]] = byte_data;
      next_st.ptr = st.ptr + 4'h1;
      next_st.done = (st.ptr == 4'(ufw_pkg::SETUP_BYTES - 1));
    end
  end
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      st <= '0;
    end else if (clk_en) begin
      st <= next_st;
    end
  end
endmodule
`default_nettype wire

// *** core/ufw_usb_window.sv ***
// Purpose: Buffer window, indexed registers and event flags of the USB engine
// Assumes: Register port and engine side share the clock
// Notes: Read data returns one cycle after the read strobe
`timescale 1ns/1ps
`default_nettype none
module ufw_usb_window (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic clk_en,
  // ----------------------------------------
  // Register port
  // ----------------------------------------
  input wire logic [7:0] sfr_addr,
  input wire logic [7:0] sfr_wdata,
  input wire logic sfr_wr,
  input wire logic sfr_rd,
  output logic [7:0] sfr_rdata,
  output logic sfr_rvalid,
  // ----------------------------------------
  // Data space port
  // ----------------------------------------
  input wire logic [15:0] xd_addr,
  input wire logic [7:0] xd_wdata,
  input wire logic xd_wr,
  input wire logic xd_rd,
  output logic [7:0] xd_rdata,
  output logic xd_hit,
  // ----------------------------------------
  // Engine side
  // ----------------------------------------
  input wire logic [3:0] sie_buf,
  input wire logic sie_out_start,
  input wire logic sie_out_end,
  input wire logic [6:0] sie_out_count,
  input wire logic sie_in_sent,
  input wire logic sie_in_refused,
  input wire logic [5:0] sie_mem_addr,
  input wire logic sie_mem_wr,
  input wire logic [7:0] sie_mem_wdata,
  output logic [7:0] sie_mem_rdata,
  input wire logic sie_bus_reset,
  input wire logic sie_idle_bus,
  input wire logic sie_packet_end,
  input wire logic sie_bus_wake,
  input wire logic sie_setup_start,
  input wire logic sie_setup_valid,
  output logic sie_setup_ready,
  input wire logic [7:0] sie_setup_data,
  input wire logic [6:0] tok_addr,
  output logic addr_match,
  output logic engine_enable,
  output logic remote_wake_request,
  output logic usb_irq
);
  typedef struct packed {
    logic [6:0] dev_addr;
    logic [3:0] pair;
    logic [3:0] ie0;
    logic [4:0] ie1;
    logic [4:0] ie2;
    logic [4:0] ie3;
    logic [3:0] if0;
    logic [4:0] if1;
    logic [4:0] if2;
    logic [4:0] if3;
    logic [2:0] ctl;
    logic [2:0] sel_ep;
    logic sel_dir;
    logic [9:0] tog;
    logic [9:0] stall;
    logic [9:0] en;
    logic [9:0] busy;
    logic [9:0][6:0] size;
    logic [3:0] active;
    logic [7:0] base_hi;
    logic [1:0] base_lo;
    logic [2:0] setup_idx;
    logic setup_seen;
    logic [7:0] rdata;
    logic rvalid;
  } ufw_st_s;
  ufw_st_s st, next_st;
  logic [7:0] mem [ufw_pkg::NUM_BUF][ufw_pkg::BUF_BYTES];
  logic [7:0] xd_q;
  logic [7:0] sie_q;
  logic [4:0] cpu_buf;
  logic [9:0] fall;
  logic [7:0] setup_byte;
  logic setup_done;
  logic cpu_win;
  logic cpu_setup_rd;
  logic buf_valid, buf_ready;
  logic [7:0] buf_data;
  // ----------------------------------------
  // Buffer mapping
  // ----------------------------------------
  // Index 0..4 are IN buffers, 5..9 OUT buffers; bit 4 flags no buffer
  function automatic logic [4:0] map_buf(input logic [2:0] ep, input logic dir,
                                         input logic [3:0] pair, input logic [3:0] active);
    logic [1:0] grp;
    logic [3:0] base;
    grp = {~dir, (ep >= 3'd3)};
    base = dir ? 4'd0 : 4'd5;
    if (ep > 3'd4) begin
      map_buf = 5'h10;
    end else if (ep != 3'd0 && !ep[0] && pair[grp]) begin
      map_buf = 5'h10;
    end else if (ep[0] && pair[grp] && active[grp]) begin
      map_buf = {1'b0, base + 4'(ep) + 4'h1};
    end else begin
      map_buf = {1'b0, base + 4'(ep)};
    end
  endfunction
  function automatic logic [1:0] pair_grp(input logic [2:0] ep, input logic dir);
    pair_grp = {~dir, (ep >= 3'd3)};
  endfunction
  assign cpu_buf = map_buf(st.sel_ep, st.sel_dir, st.pair, st.active);
  assign xd_hit = st.ctl[ufw_pkg::CTL_WINDOW_ENABLE] && (xd_addr[15:6] == {st.base_hi, st.base_lo});
  assign cpu_win = xd_hit && !cpu_buf[4] && !st.busy[cpu_buf[3:0]];
  assign cpu_setup_rd = sfr_rd && (sfr_addr == ufw_pkg::OFS_SETUP_VALUE);
  assign addr_match = (tok_addr == st.dev_addr);
  assign engine_enable = st.ctl[ufw_pkg::CTL_ENGINE_ENABLE];
  assign remote_wake_request = st.ctl[ufw_pkg::CTL_REMOTE_WAKE];
  assign usb_irq = |(st.if0 & st.ie0) | |(st.if1 & st.ie1) | |(st.if2 & st.ie2) | |(st.if3 & st.ie3);
  assign sfr_rdata = st.rdata;
  assign sfr_rvalid = st.rvalid;
  assign xd_rdata = xd_q;
  assign sie_mem_rdata = sie_q;
  // ----------------------------------------
  // Setup path
  // ----------------------------------------
  // The buffer lets a processor read stall the store without dropping a byte
  ufw_two_entry_buffer #(.WIDTH(8)) u_setup_buf (
    .clock(clock),
    .rst_b(rst_b),
    .clk_en(clk_en),
    .in_valid(sie_setup_valid),
    .in_ready(sie_setup_ready),
    .in_data(sie_setup_data),
    .out_valid(buf_valid),
    .out_ready(buf_ready),
    .out_data(buf_data)
  );
  ufw_setup_store u_setup (
    .clock(clock),
    .rst_b(rst_b),
    .clk_en(clk_en),
    .start(sie_setup_start),
    .byte_valid(buf_valid),
    .byte_ready(buf_ready),
    .byte_data(buf_data),
    .cpu_busy(cpu_setup_rd),
    .rd_index(st.setup_idx),
    .rd_byte(setup_byte),
    .done(setup_done)
  );
  // ----------------------------------------
  // Register logic
  // ----------------------------------------
  always_comb begin
    logic [9:0] busy_now;
    logic cb_ok;
    busy_now = '0;
    cb_ok = 1'b0;
    next_st = st;
    cb_ok = !cpu_buf[4] && !st.busy[cpu_buf[3:0]];
    next_st.rvalid = sfr_rd;
    next_st.rdata = 8'h00;
    if (sfr_rd) begin
      unique case (sfr_addr)
        ufw_pkg::OFS_DEVICE_ADDRESS: next_st.rdata = {1'b0, st.dev_addr};
        ufw_pkg::OFS_PAIRING: next_st.rdata = {4'h0, st.pair};
        ufw_pkg::OFS_GLOBAL_ENABLE: next_st.rdata = {4'h0, st.ie0};
        ufw_pkg::OFS_IN_DONE_ENABLE: next_st.rdata = {3'h0, st.ie1};
        ufw_pkg::OFS_OUT_DONE_ENABLE: next_st.rdata = {3'h0, st.ie2};
        ufw_pkg::OFS_IN_REFUSED_ENABLE: next_st.rdata = {3'h0, st.ie3};
        ufw_pkg::OFS_GLOBAL_FLAGS: next_st.rdata = {usb_irq, |st.if1, |st.if2, |st.if3, st.if0};
        ufw_pkg::OFS_IN_DONE_FLAGS: next_st.rdata = {3'h0, st.if1};
        ufw_pkg::OFS_OUT_DONE_FLAGS: next_st.rdata = {3'h0, st.if2};
        ufw_pkg::OFS_IN_REFUSED_FLAGS: next_st.rdata = {3'h0, st.if3};
        ufw_pkg::OFS_ENGINE_CONTROL: next_st.rdata = {5'h00, st.ctl};
        ufw_pkg::OFS_ENGINE_STATUS: next_st.rdata = {7'h00, st.setup_seen};
        ufw_pkg::OFS_SELECT: next_st.rdata = {st.sel_dir, 4'h0, st.sel_ep};
        ufw_pkg::OFS_BUFFER_CONTROL: begin
          if (!cpu_buf[4]) begin
            next_st.rdata = {st.tog[cpu_buf[3:0]], st.stall[cpu_buf[3:0]], 2'h0,
                             st.en[cpu_buf[3:0]], 2'h0, st.busy[cpu_buf[3:0]]};
          end
        end
        ufw_pkg::OFS_BUFFER_SIZE: begin
          if (!cpu_buf[4]) begin
            next_st.rdata = {1'b0, st.size[cpu_buf[3:0]]};
          end
        end
        ufw_pkg::OFS_BASE_HIGH: next_st.rdata = st.base_hi;
        ufw_pkg::OFS_BASE_LOW: next_st.rdata = {st.base_lo, 6'h00};
        ufw_pkg::OFS_SETUP_INDEX: next_st.rdata = {5'h00, st.setup_idx};
        ufw_pkg::OFS_SETUP_VALUE: next_st.rdata = setup_byte;
        default: next_st.rdata = 8'h00;
      endcase
    end
    if (sfr_wr) begin
      unique case (sfr_addr)
        ufw_pkg::OFS_DEVICE_ADDRESS: next_st.dev_addr = sfr_wdata[6:0];
        ufw_pkg::OFS_PAIRING: next_st.pair = sfr_wdata[3:0];
        ufw_pkg::OFS_GLOBAL_ENABLE: next_st.ie0 = sfr_wdata[3:0];
        ufw_pkg::OFS_IN_DONE_ENABLE: next_st.ie1 = sfr_wdata[4:0];
        ufw_pkg::OFS_OUT_DONE_ENABLE: next_st.ie2 = sfr_wdata[4:0];
        ufw_pkg::OFS_IN_REFUSED_ENABLE: next_st.ie3 = sfr_wdata[4:0];
        // Writing zero clears a flag; a one leaves it alone
        ufw_pkg::OFS_GLOBAL_FLAGS: next_st.if0 = st.if0 & sfr_wdata[3:0];
        ufw_pkg::OFS_IN_DONE_FLAGS: next_st.if1 = st.if1 & sfr_wdata[4:0];
        ufw_pkg::OFS_OUT_DONE_FLAGS: next_st.if2 = st.if2 & sfr_wdata[4:0];
        ufw_pkg::OFS_IN_REFUSED_FLAGS: next_st.if3 = st.if3 & sfr_wdata[4:0];
        ufw_pkg::OFS_ENGINE_CONTROL: next_st.ctl = sfr_wdata[2:0];
        ufw_pkg::OFS_SELECT: begin
          next_st.sel_ep = sfr_wdata[2:0];
          next_st.sel_dir = sfr_wdata[ufw_pkg::SEL_DIR];
        end
        ufw_pkg::OFS_BUFFER_CONTROL: begin
          if (cb_ok) begin
            next_st.tog[cpu_buf[3:0]] = sfr_wdata[ufw_pkg::CON_TOGGLE];
            next_st.stall[cpu_buf[3:0]] = sfr_wdata[ufw_pkg::CON_STALL];
            next_st.en[cpu_buf[3:0]] = sfr_wdata[ufw_pkg::CON_ENABLE];
          end
        end
        ufw_pkg::OFS_BUFFER_SIZE: begin
          if (cb_ok) begin
            next_st.size[cpu_buf[3:0]] = sfr_wdata[6:0];
            if (st.sel_dir) begin
              next_st.busy[cpu_buf[3:0]] = 1'b1;
            end
            if (st.sel_ep[0] && st.pair[pair_grp(st.sel_ep, st.sel_dir)]) begin
              next_st.active[pair_grp(st.sel_ep, st.sel_dir)] = ~st.active[pair_grp(st.sel_ep, st.sel_dir)];
            end
          end
        end
        ufw_pkg::OFS_BASE_HIGH: next_st.base_hi = sfr_wdata;
        ufw_pkg::OFS_BASE_LOW: next_st.base_lo = sfr_wdata[7:6];
        ufw_pkg::OFS_SETUP_INDEX: begin
          next_st.setup_idx = sfr_wdata[2:0];
          next_st.setup_seen = 1'b0;
        end
        default: next_st.setup_seen = next_st.setup_seen;
      endcase
    end
    // Engine events are applied after processor writes so an engine set wins over a processor clear
    if (sie_buf < 4'd10) begin
      if (sie_out_start) begin
        next_st.busy[sie_buf] = 1'b1;
      end
      if (sie_out_end) begin
        next_st.busy[sie_buf] = 1'b0;
        next_st.size[sie_buf] = sie_out_count;
      end
      if (sie_in_sent) begin
        next_st.busy[sie_buf] = 1'b0;
      end
      if (sie_in_refused && sie_buf < 4'd5) begin
        next_st.if3[sie_buf[2:0]] = 1'b1;
      end
    end
    busy_now = next_st.busy;
    for (int i = 0; i < ufw_pkg::NUM_EP; i++) begin
      if (st.busy[i] && !busy_now[i]) begin
        next_st.if1[i] = 1'b1;
      end
      if (st.busy[i+5] && !busy_now[i+5]) begin
        next_st.if2[i] = 1'b1;
      end
    end
    if (sie_bus_reset) next_st.if0[3] = 1'b1;
    if (sie_idle_bus) next_st.if0[2] = 1'b1;
    if (sie_packet_end) next_st.if0[1] = 1'b1;
    if (sie_bus_wake) next_st.if0[0] = 1'b1;
    if (setup_done) next_st.setup_seen = 1'b1;
  end
  always_comb begin
    fall = st.busy & ~next_st.busy;
  end
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      st <= '0;
      st.dev_addr <= ufw_pkg::RST_DEVICE_ADDRESS;
      st.en <= {ufw_pkg::NUM_BUF{ufw_pkg::RST_BUFFER_CONTROL[ufw_pkg::CON_ENABLE]}};
    end else if (clk_en) begin
      st <= next_st;
    end
  end
  // ----------------------------------------
  // Buffer memory
  // ----------------------------------------
  // No reset on the array; the engine keeps using it while the window is closed
  always_ff @(posedge clock) begin
    if (clk_en) begin
      if (xd_wr && cpu_win) begin
        mem[cpu_buf[3:0]][xd_addr[5:0]] <= xd_wdata;
      end
      if (sie_mem_wr && sie_buf < 4'd10) begin
        mem[sie_buf][sie_mem_addr] <= sie_mem_wdata;
      end
    end
  end
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      xd_q <= 8'h00;
      sie_q <= 8'h00;
    end else if (clk_en) begin
      xd_q <= (xd_rd && cpu_win) ? mem[cpu_buf[3:0]][xd_addr[5:0]] : 8'h00;
      sie_q <= (sie_buf < 4'd10) ? mem[sie_buf][sie_mem_addr] : 8'h00;
    end
  end
  // ----------------------------------------
  // Checks
  // ----------------------------------------
  sequence s_size_wr;
    clk_en && sfr_wr && sfr_addr == ufw_pkg::OFS_BUFFER_SIZE && !cpu_buf[4] && !st.busy[cpu_buf[3:0]];
  endsequence
  sequence s_paired_wr;
    s_size_wr ##0 (st.sel_ep[0] && st.pair[pair_grp(st.sel_ep, st.sel_dir)]);
  endsequence
  property p_in_size_busy;
    @(posedge clock) disable iff (!rst_b)
    (s_size_wr ##0 st.sel_dir) |=> st.busy[$past(cpu_buf[3:0])];
  endproperty
  a_in_size_busy: assert property (p_in_size_busy) else $error("IN size write did not set busy");
  property p_pair_swap;
    @(posedge clock) disable iff (!rst_b)
    s_paired_wr |=> (st.active != $past(st.active));
  endproperty
  a_pair_swap: assert property (p_pair_swap) else $error("paired size write kept active buffer");
  property p_out_end;
    @(posedge clock) disable iff (!rst_b)
    (clk_en && sie_out_end && sie_buf < 4'd10 && !sie_out_start)
      |=> (!st.busy[$past(sie_buf)] && st.size[$past(sie_buf)] == $past(sie_out_count));
  endproperty
  a_out_end: assert property (p_out_end) else $error("OUT end did not load count");
  property p_fall_flag;
    @(posedge clock) disable iff (!rst_b)
    (clk_en && fall[4:0] != 5'h00) |=> ((st.if1 & $past(fall[4:0])) == $past(fall[4:0]));
  endproperty
  a_fall_flag: assert property (p_fall_flag) else $error("busy fall left flag clear");
  property p_irq_raise;
    @(posedge clock) disable iff (!rst_b)
    (clk_en && (fall[9:5] & st.ie2) != 5'h00 && !(sfr_wr && sfr_addr == ufw_pkg::OFS_OUT_DONE_ENABLE))
      |=> usb_irq;
  endproperty
  a_irq_raise: assert property (p_irq_raise) else $error("enabled event gave no interrupt");
  property p_window_closed;
    @(posedge clock) disable iff (!rst_b)
    (clk_en && xd_rd && !st.ctl[ufw_pkg::CTL_WINDOW_ENABLE]) |=> (xd_rdata == 8'h00 && !$past(xd_hit));
  endproperty
  a_window_closed: assert property (p_window_closed) else $error("closed window reached a buffer");
  property p_addr_zero;
    @(posedge clock) disable iff (!rst_b)
    (st.dev_addr == 7'h00 && tok_addr == 7'h00) |-> addr_match;
  endproperty
  a_addr_zero: assert property (p_addr_zero) else $error("address zero not answered");
  property p_addr_assigned;
    @(posedge clock) disable iff (!rst_b)
    (clk_en && sfr_wr && sfr_addr == ufw_pkg::OFS_DEVICE_ADDRESS) ##1 (tok_addr != $past(sfr_wdata[6:0]))
      |-> !addr_match;
  endproperty
  a_addr_assigned: assert property (p_addr_assigned) else $error("foreign address answered");
  property p_size_read;
    @(posedge clock) disable iff (!rst_b)
    (clk_en && sfr_rd && sfr_addr == ufw_pkg::OFS_BUFFER_SIZE && !cpu_buf[4])
      |=> (sfr_rvalid && sfr_rdata == {1'b0, $past(st.size[cpu_buf[3:0]])});
  endproperty
  a_size_read: assert property (p_size_read) else $error("size read not from selected buffer");
endmodule
`default_nettype wire

// *** verification/ufw_engine_model.sv ***
// Purpose: Engine-side source of setup packet bytes
// Assumes: Bytes are held until ready is seen high at an edge
// Notes: Data line shows the inverse of the last byte once released
`timescale 1ns/1ps
`default_nettype none
module ufw_engine_model (
  input wire logic clock,
  output var logic sie_setup_start,
  output var logic sie_setup_valid,
  input wire logic sie_setup_ready,
  output var logic [7:0] sie_setup_data
);
  initial begin
    sie_setup_start = 1'b0;
    sie_setup_valid = 1'b0;
    sie_setup_data = 8'h00;
  end
  task automatic send_setup(input logic [7:0] b);
    @(posedge clock);
    #1 sie_setup_start = 1'b1;
    @(posedge clock);
    #1 sie_setup_start = 1'b0;
    for (int i = 0; i < 8; i++) begin
      sie_setup_valid = 1'b1;
      sie_setup_data = b + 8'(i);
      while (!sie_setup_ready) begin
        @(posedge clock);
        #1;
      end
      @(posedge clock);
      #1;
    end
    sie_setup_valid = 1'b0;
    sie_setup_data = ~sie_setup_data;
  endtask
endmodule
`default_nettype wire

// *** verification/ufw_usb_window_bench.sv ***
// Purpose: Self-checking bench for the USB buffer window block
// Assumes: Strobes are one-cycle pulses driven 1 ns after the edge
// Notes: Engine pulses are driven inline; setup bytes come from the partner model
`timescale 1ns/1ps
`default_nettype none
module ufw_usb_window_bench;
  logic clock = 1'b0, rst_b = 1'b0, sfr_wr = 1'b0, sfr_rd = 1'b0, xd_wr = 1'b0, xd_rd = 1'b0;
  logic [7:0] sfr_addr = 8'h00, sfr_wdata = 8'h00, xd_wdata = 8'h00;
  logic [7:0] sfr_rdata, xd_rdata, sie_mem_rdata, sie_setup_data;
  logic [15:0] xd_addr = 16'h0000;
  logic [3:0] sie_buf = 4'h0, gev = 4'h0;
  logic [6:0] tok_addr = 7'h00, sie_out_count = 7'h00;
  logic sie_in_sent = 1'b0, sie_in_refused = 1'b0, sie_out_start = 1'b0, sie_out_end = 1'b0;
  logic sfr_rvalid, xd_hit, sie_setup_start, sie_setup_valid, sie_setup_ready;
  logic addr_match, engine_enable, remote_wake_request, usb_irq;
  wire logic clk_en = 1'b1;
  logic sie_mem_wr = 1'b0;
  logic [5:0] sie_mem_addr = 6'h00;
  logic [7:0] sie_mem_wdata = 8'h00;
  int mismatches = 0, check_count = 0;
  logic [15:0] rv [11] = '{16'he200, 16'he400, 16'he500, 16'he600, 16'he700, 16'he800,
                           16'he900, 16'hea00, 16'heb00, 16'hec00, 16'hf108};
  always #10 clock = ~clock;
  ufw_engine_model u_eng (.*);
  ufw_usb_window u_dut (.*, .sie_bus_reset(gev[3]), .sie_idle_bus(gev[2]), .sie_packet_end(gev[1]),
                        .sie_bus_wake(gev[0]));
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    check_count++;
    if (g !== e) begin
      mismatches++;
      $display("FAIL %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    #1 sfr_addr = a;
    sfr_wdata = d;
    sfr_wr = 1'b1;
    @(posedge clock);
    #1 sfr_wr = 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge clock);
    #1 sfr_addr = a;
    sfr_rd = 1'b1;
    @(posedge clock);
    #1 sfr_rd = 1'b0;
    chk("sfr_rdata", e, sfr_rdata);
    chk("sfr_rvalid", 8'h01, {7'h00, sfr_rvalid});
  endtask
  // Write when w is set, else read and compare with d
  task automatic xa(input logic w, input logic [15:0] a, input logic [7:0] d);
    @(posedge clock);
    #1 xd_addr = a;
    xd_wdata = d;
    xd_wr = w;
    xd_rd = !w;
    @(posedge clock);
    #1 xd_wr = 1'b0;
    xd_rd = 1'b0;
    if (!w) chk("xd_rdata", d, xd_rdata);
  endtask
  task automatic pulse(ref logic s);
    @(posedge clock);
    #1 s = 1'b1;
    @(posedge clock);
    #1 s = 1'b0;
  endtask
  task automatic test_done();
    $display("mismatches %0d check_count %0d", mismatches, check_count);
    if (mismatches == 0 && check_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  initial begin
    #100000;
    mismatches++;
    test_done();
  end
  initial begin
    repeat (16) @(posedge clock);
    #1 rst_b = 1'b1;
    foreach (rv[i]) rd(rv[i][15:8], rv[i][7:0]);
    chk("addr_match", 8'h01, {7'h00, addr_match});
    wr(8'he2, 8'h15);
    #1 chk("addr_match", 8'h00, {7'h00, addr_match});
    @(posedge clock);
    #1 tok_addr = 7'h15;
    #1 chk("addr_match", 8'h01, {7'h00, addr_match});
    wr(8'hec, 8'h05);
    chk("engine_enable", 8'h01, {7'h00, engine_enable});
    chk("remote_wake_request", 8'h01, {7'h00, remote_wake_request});
    wr(8'hec, 8'h02);
    wr(8'hef, 8'h81);
    wr(8'hf3, 8'h40);
    wr(8'hf4, 8'h80);
    xa(1'b1, 16'h4085, 8'h5a);
    xa(1'b0, 16'h4085, 8'h5a);
    chk("xd_hit", 8'h01, {7'h00, xd_hit});
    xa(1'b0, 16'h4045, 8'h00);
    chk("xd_hit", 8'h00, {7'h00, xd_hit});
    wr(8'hec, 8'h00);
    xa(1'b0, 16'h4085, 8'h00);
    chk("xd_hit", 8'h00, {7'h00, xd_hit});
    // Engine side keeps its buffer access while the window is closed
    sie_buf = 4'h1;
    sie_mem_addr = 6'h05;
    @(posedge clock);
    #1 chk("sie_mem_rdata", 8'h5a, sie_mem_rdata);
    sie_mem_addr = 6'h06;
    sie_mem_wdata = 8'hc3;
    pulse(sie_mem_wr);
    wr(8'hec, 8'h02);
    xa(1'b0, 16'h4086, 8'hc3);
    wr(8'he5, 8'h02);
    wr(8'hf2, 8'h05);
    rd(8'hf1, 8'h09);
    xa(1'b0, 16'h4085, 8'h00);
    sie_buf = 4'h1;
    pulse(sie_in_sent);
    rd(8'he9, 8'h02);
    chk("usb_irq", 8'h01, {7'h00, usb_irq});
    wr(8'he9, 8'h00);
    chk("usb_irq", 8'h00, {7'h00, usb_irq});
    // Endpoint 1 OUT is physical buffer 6
    wr(8'hef, 8'h01);
    wr(8'he6, 8'h02);
    sie_buf = 4'h6;
    sie_out_count = 7'h2a;
    pulse(sie_out_start);
    rd(8'hf1, 8'h09);
    pulse(sie_out_end);
    rd(8'hf2, 8'h2a);
    rd(8'hea, 8'h02);
    chk("usb_irq", 8'h01, {7'h00, usb_irq});
    wr(8'hea, 8'h00);
    wr(8'he3, 8'h01);
    wr(8'hef, 8'h82);
    rd(8'hf1, 8'h00);
    // Size write through the odd endpoint swaps to the idle partner
    wr(8'hef, 8'h81);
    wr(8'hf2, 8'h10);
    rd(8'hf1, 8'h08);
    wr(8'he4, 8'h0f);
    for (int i = 0; i < 4; i++) begin
      @(posedge clock);
      #1 gev[i] = 1'b1;
      @(posedge clock);
      #1 gev = 4'h0;
      rd(8'he8, 8'h80 | (8'h01 << i));
      wr(8'he8, 8'h00);
    end
    sie_buf = 4'h3;
    pulse(sie_in_refused);
    rd(8'heb, 8'h08);
    rd(8'he8, 8'h10);
    wr(8'he2, 8'h00);
    tok_addr = 7'h00;
    #1 chk("addr_match", 8'h01, {7'h00, addr_match});
    u_eng.send_setup(8'h30);
    @(posedge clock);
    rd(8'hed, 8'h01);
    for (int k = 0; k < 8; k++) begin
      wr(8'hf5, 8'(k));
      rd(8'hf6, 8'h30 + 8'(k));
    end
    test_done();
  end
endmodule
`default_nettype wire
